//--- verilog/dual_port_flag_ctrl.sv
// controller driving one port of a dual-port ram with hardware flags
// Operation
// RL1: device offers shared 4K x 8 memory
// RL2: only same-address write collisions conflict
// RL3: device has eight independent flag latches
// RL4: flag chosen by low three address bits
// RL5: flags active low; zero requests, one releases
// RL6: only data bit 0 written to flag
// RL7: free flag taken reads zero here only
// RL8: owner writing one frees the flag
// RL9: pending other-side request inherits freed token
// RL10: failed request latched, flag reads one
// RL11: flag read replicated on all bits
// RL12: flag read frozen while select and enable
// RL13: earliest requester wins, ties go arbitrarily
// RL14: spacing violation still settles to one side
// RL15: memory select high through flag write/read
// RL16: acquire by write zero, then read back
// RL17: after failure reread or write one
// RL18: write one to every flag at init
// RL19: both selects high puts port standby
// RL20: flag read drives flag onto data
// RL21: flag written on read/write rising edge
// RL22: memory read drives addressed word
// RL23: memory write stores data lines
// RL24: select condition held whole write interval
// RL25: never both selects low together
module dual_port_flag_ctrl (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic cmd_valid_i,
	input dual_port_flag_pkg::cmd_t cmd_i,
	output logic cmd_ready_o,
	output logic done_o,
	output dual_port_flag_pkg::rsp_t rsp_o,
	output logic [dual_port_flag_pkg::ADDR_W-1:0] addr_o,
	output logic mem_select_n_o,
	output logic flag_select_n_o,
	output logic rw_o,
	output logic oe_n_o,
	output logic [dual_port_flag_pkg::DATA_W-1:0] data_o,
	output logic data_oe_o,
	input wire logic [dual_port_flag_pkg::DATA_W-1:0] data_i
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_WR_SETUP,
		ST_WR_PULSE,
		ST_WR_HOLD,
		ST_RD_WAIT,
		ST_WITHDRAW
	} state_t;

	state_t state;
	state_t next_state;
	dual_port_flag_pkg::pins_t pins;
	dual_port_flag_pkg::pins_t next_pins;
	dual_port_flag_pkg::cmd_t cmd;
	dual_port_flag_pkg::cmd_t next_cmd;
	dual_port_flag_pkg::rsp_t rsp;
	dual_port_flag_pkg::rsp_t next_rsp;
	logic [dual_port_flag_pkg::CNT_W-1:0] cnt;
	logic [dual_port_flag_pkg::CNT_W-1:0] next_cnt;
	logic init_busy;
	logic next_init_busy;
	logic [dual_port_flag_pkg::FLAG_IDX_W-1:0] init_idx;
	logic [dual_port_flag_pkg::FLAG_IDX_W-1:0] next_init_idx;
	logic withdrawing;
	logic next_withdrawing;
	logic done;
	logic next_done;
	logic ready;
	logic next_ready;
	logic [dual_port_flag_pkg::DATA_W-1:0] data_sync;

	// ----------------------------------------------------------------
	// data pins pass two flops before use
	// ----------------------------------------------------------------
	pin_sync2 #(
		.WIDTH(dual_port_flag_pkg::DATA_W)
	) u_data_sync (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.d_i(data_i),
		.q_o(data_sync)
	);

	// ----------------------------------------------------------------
	// pin setup for one access
	// ----------------------------------------------------------------
	function automatic dual_port_flag_pkg::pins_t start_access(
		input logic is_flag,
		input logic is_write,
		input logic [dual_port_flag_pkg::ADDR_W-1:0] addr,
		input logic [dual_port_flag_pkg::DATA_W-1:0] wdata
	);
		dual_port_flag_pkg::pins_t p;
		p = dual_port_flag_pkg::PINS_IDLE;
		if (is_flag) begin
			// only the index bits carry meaning; the rest held low
			p.addr = {{(dual_port_flag_pkg::ADDR_W - dual_port_flag_pkg::FLAG_IDX_W){1'b0}},
				addr[dual_port_flag_pkg::FLAG_IDX_W-1:0]}; // RL4
			p.flag_select_n = 1'b0; // RL15
		end else begin
			p.addr = addr; // RL1
			p.mem_select_n = 1'b0; // RL25
		end
		p.rw = 1'b1;
		p.oe_n = is_write;
		p.dout = wdata;
		p.dout_en = is_write;
		return p;
	endfunction

	// ----------------------------------------------------------------
	// sequencer next values
	// ----------------------------------------------------------------
	always_comb begin
		next_state = state;
		next_pins = pins;
		next_cmd = cmd;
		next_rsp = rsp;
		next_cnt = cnt;
		next_init_busy = init_busy;
		next_init_idx = init_idx;
		next_withdrawing = withdrawing;
		next_done = 1'b0;
		case (state)
			ST_IDLE: begin
				if (init_busy) begin
					// free every flag from this side after reset
					next_pins = start_access(1'b1, 1'b1,
						{{(dual_port_flag_pkg::ADDR_W - dual_port_flag_pkg::FLAG_IDX_W){1'b0}},
						init_idx}, dual_port_flag_pkg::FLAG_FREE_DATA); // RL18
					next_state = ST_WR_SETUP;
				end else if (cmd_valid_i && ready) begin
					next_cmd = cmd_i;
					next_withdrawing = 1'b0;
					case (cmd_i.kind)
						dual_port_flag_pkg::CMD_MEM_READ: begin
							next_pins = start_access(1'b0, 1'b0, cmd_i.addr, cmd_i.wdata); // RL22
						end
						dual_port_flag_pkg::CMD_MEM_WRITE: begin
							next_pins = start_access(1'b0, 1'b1, cmd_i.addr, cmd_i.wdata); // RL23
						end
						dual_port_flag_pkg::CMD_FLAG_ACQUIRE: begin
							// write zero first, never read first
							next_pins = start_access(1'b1, 1'b1, cmd_i.addr,
								dual_port_flag_pkg::FLAG_TAKE_DATA); // RL16 RL5
						end
						dual_port_flag_pkg::CMD_FLAG_RELEASE: begin
							next_pins = start_access(1'b1, 1'b1, cmd_i.addr,
								dual_port_flag_pkg::FLAG_FREE_DATA); // RL5 RL8
						end
						default: begin
							next_pins = start_access(1'b1, 1'b0, cmd_i.addr, cmd_i.wdata); // RL20
						end
					endcase
					if (cmd_i.kind == dual_port_flag_pkg::CMD_MEM_READ ||
						cmd_i.kind == dual_port_flag_pkg::CMD_FLAG_READ) begin
						next_cnt = dual_port_flag_pkg::CNT_W'(dual_port_flag_pkg::READ_WAIT_CYC - 1);
						next_state = ST_RD_WAIT;
					end else begin
						next_state = ST_WR_SETUP;
					end
				end
			end
			ST_WR_SETUP: begin
				// selects already stable; open the write strobe
				next_pins.rw = 1'b0; // RL24
				next_cnt = dual_port_flag_pkg::CNT_W'(dual_port_flag_pkg::WRITE_PULSE_CYC - 1);
				next_state = ST_WR_PULSE;
			end
			ST_WR_PULSE: begin
				if (cnt == '0) begin
					// rising read/write ends the write, data still held
					next_pins.rw = 1'b1; // RL21
					next_state = ST_WR_HOLD;
				end else begin
					next_cnt = cnt - 1'b1;
				end
			end
			ST_WR_HOLD: begin
				if (!init_busy && !withdrawing &&
					cmd.kind == dual_port_flag_pkg::CMD_FLAG_ACQUIRE) begin
					// read back with memory select still high
					next_pins.dout_en = 1'b0;
					next_pins.oe_n = 1'b0; // RL16 RL15
					next_cnt = dual_port_flag_pkg::CNT_W'(dual_port_flag_pkg::READ_WAIT_CYC - 1);
					next_state = ST_RD_WAIT;
				end else begin
					next_pins = dual_port_flag_pkg::PINS_IDLE; // RL19
					next_state = ST_IDLE;
					if (init_busy) begin
						if (init_idx == dual_port_flag_pkg::FLAG_IDX_LAST) begin
							next_init_busy = 1'b0;
						end else begin
							next_init_idx = init_idx + 1'b1;
						end
					end else begin
						next_done = 1'b1;
						if (!withdrawing) begin
							next_rsp.granted = 1'b0;
							next_rsp.rdata = dual_port_flag_pkg::DATA_RESET;
						end
					end
				end
			end
			ST_RD_WAIT: begin
				if (cnt == '0) begin
					// dropping selects and enable unfreezes the flag latch
					next_pins = dual_port_flag_pkg::PINS_IDLE; // RL12 RL19
					next_rsp.rdata = data_sync; // RL11
					next_rsp.granted = ~data_sync[dual_port_flag_pkg::FLAG_WRITE_BIT];
					if (cmd.kind == dual_port_flag_pkg::CMD_FLAG_ACQUIRE &&
						data_sync[dual_port_flag_pkg::FLAG_WRITE_BIT]) begin
						// lost: pull back the pending request
						next_state = ST_WITHDRAW; // RL17 RL10
					end else begin
						next_done = 1'b1;
						next_state = ST_IDLE;
					end
				end else begin
					next_cnt = cnt - 1'b1;
				end
			end
			ST_WITHDRAW: begin
				next_withdrawing = 1'b1;
				next_pins = start_access(1'b1, 1'b1, cmd.addr,
					dual_port_flag_pkg::FLAG_FREE_DATA); // RL17 RL9
				next_state = ST_WR_SETUP;
			end
			default: begin
				next_pins = dual_port_flag_pkg::PINS_IDLE;
				next_state = ST_IDLE;
			end
		endcase
		next_ready = (next_state == ST_IDLE) && !next_init_busy;
	end

	// ----------------------------------------------------------------
	// sequencer registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			state <= ST_IDLE;
			pins <= dual_port_flag_pkg::PINS_IDLE;
			cmd <= '0;
			rsp <= '0;
			cnt <= '0;
			init_busy <= 1'b1;
			init_idx <= '0;
			withdrawing <= 1'b0;
			done <= 1'b0;
			ready <= 1'b0;
		end else begin
			state <= next_state;
			pins <= next_pins;
			cmd <= next_cmd;
			rsp <= next_rsp;
			cnt <= next_cnt;
			init_busy <= next_init_busy;
			init_idx <= next_init_idx;
			withdrawing <= next_withdrawing;
			done <= next_done;
			ready <= next_ready;
		end
	end

	// ----------------------------------------------------------------
	// outputs straight from registers
	// ----------------------------------------------------------------
	assign cmd_ready_o = ready;
	assign done_o = done;
	assign rsp_o = rsp;
	assign addr_o = pins.addr;
	assign mem_select_n_o = pins.mem_select_n;
	assign flag_select_n_o = pins.flag_select_n;
	assign rw_o = pins.rw;
	assign oe_n_o = pins.oe_n;
	assign data_o = pins.dout;
	assign data_oe_o = pins.dout_en;

endmodule

//--- verilog/dual_port_flag_pkg.sv
// shared constants and types for the dual-port ram and flag controller
package dual_port_flag_pkg;

	// ----------------------------------------------------------------
	// widths and flag space
	// ----------------------------------------------------------------
	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;
	localparam int FLAG_COUNT = 8;
	localparam int FLAG_IDX_W = 3;
	localparam int FLAG_WRITE_BIT = 0;
	localparam int CNT_W = 4;

	// ----------------------------------------------------------------
	// timing, in ns and in 100 ns clock cycles
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 100;
	localparam int WRITE_PULSE_NS = 60;
	localparam int READ_ACCESS_NS = 70;
	localparam int SYNC_STAGES = 2;
	localparam int WRITE_PULSE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int READ_ACCESS_CYC = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int READ_WAIT_CYC = READ_ACCESS_CYC + SYNC_STAGES;

	// ----------------------------------------------------------------
	// data values and pin idle levels
	// ----------------------------------------------------------------
	localparam logic [DATA_W-1:0] FLAG_FREE_DATA = 8'hff;
	localparam logic [DATA_W-1:0] FLAG_TAKE_DATA = 8'h00;
	localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_RESET = 12'h000;
	localparam logic [FLAG_IDX_W-1:0] FLAG_IDX_LAST = 3'h7;

	// ----------------------------------------------------------------
	// command port and pin bundle
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		CMD_MEM_READ,
		CMD_MEM_WRITE,
		CMD_FLAG_ACQUIRE,
		CMD_FLAG_RELEASE,
		CMD_FLAG_READ
	} cmd_kind_t;

	typedef struct packed {
		cmd_kind_t kind;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} cmd_t;

	typedef struct packed {
		logic [DATA_W-1:0] rdata;
		logic granted;
	} rsp_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic mem_select_n;
		logic flag_select_n;
		logic rw;
		logic oe_n;
		logic [DATA_W-1:0] dout;
		logic dout_en;
	} pins_t;

	localparam pins_t PINS_IDLE = '{ADDR_RESET, 1'b1, 1'b1, 1'b1, 1'b1, DATA_RESET, 1'b0};

endpackage

//--- verilog/pin_sync2.sv
// two-flop synchroniser for pin inputs
module pin_sync2 #(
	parameter int WIDTH = 8
) (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic [WIDTH-1:0] d_i,
	output logic [WIDTH-1:0] q_o
);

	// refuse a width the flops cannot hold
	if (WIDTH < 1) begin : g_width_check
		$error("pin_sync2: WIDTH must be at least 1");
	end

	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;

	// first stage feeds only the second
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			stage1 <= '0;
			stage2 <= '0;
		end else begin
			stage1 <= d_i;
			stage2 <= stage1;
		end
	end

	assign q_o = stage2;

endmodule

//--- verification/flag_ctrl_sva.sv
// bound assertions on the ports of the flag controller
module flag_ctrl_sva (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic cmd_valid_i,
	input dual_port_flag_pkg::cmd_t cmd_i,
	input wire logic cmd_ready_o,
	input wire logic done_o,
	input dual_port_flag_pkg::rsp_t rsp_o,
	input wire logic [11:0] addr_o,
	input wire logic mem_select_n_o,
	input wire logic flag_select_n_o,
	input wire logic rw_o,
	input wire logic oe_n_o,
	input wire logic [7:0] data_o,
	input wire logic data_oe_o
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	wire logic take = cmd_valid_i && cmd_ready_o;
	// ----------------------------------------------------------------
	// access shapes
	// ----------------------------------------------------------------
	sequence wr_s(sel_n, b);
		(rw_o && !sel_n && data_oe_o && data_o[0] == b) ##1 (!rw_o && !sel_n) ##1 (rw_o && !sel_n);
	endsequence
	sequence rd_s(sel_n);
		(!sel_n && !oe_n_o && rw_o) [*3];
	endsequence
	sel_excl_a: assert property (mem_select_n_o || flag_select_n_o)
		else $error("both selects low");
	write_hold_a: assert property ($fell(rw_o) |-> $stable({addr_o, mem_select_n_o,
		flag_select_n_o, data_o}) ##1 (rw_o && $stable({addr_o, data_o}))) else $error("write moved");
	flag_addr_a: assert property (!flag_select_n_o |-> addr_o[11:3] == 9'h000)
		else $error("flag address high bits set");
	done_idle_a: assert property (done_o |-> cmd_ready_o && mem_select_n_o && flag_select_n_o
		&& oe_n_o && !data_oe_o) else $error("pins busy at done");
	take_drop_a: assert property (take |=> !cmd_ready_o && !done_o)
		else $error("ready after take");
	mem_read_a: assert property (take && cmd_i.kind == dual_port_flag_pkg::CMD_MEM_READ
		|=> rd_s(mem_select_n_o) ##1 done_o) else $error("memory read shape");
	flag_read_a: assert property (take && cmd_i.kind == dual_port_flag_pkg::CMD_FLAG_READ
		|=> rd_s(flag_select_n_o) ##1 (done_o && rsp_o.granted == !rsp_o.rdata[0]
		&& (rsp_o.rdata == 8'h00 || rsp_o.rdata == 8'hff))) else $error("flag read shape");
	mem_write_a: assert property (take && cmd_i.kind == dual_port_flag_pkg::CMD_MEM_WRITE
		|=> wr_s(mem_select_n_o, $past(cmd_i.wdata[0])) ##1 done_o) else $error("memory write shape");
	release_a: assert property (take && cmd_i.kind == dual_port_flag_pkg::CMD_FLAG_RELEASE
		|=> wr_s(flag_select_n_o, 1'b1) ##1 done_o) else $error("release shape");
	acquire_a: assert property (take && cmd_i.kind == dual_port_flag_pkg::CMD_FLAG_ACQUIRE
		|=> wr_s(flag_select_n_o, 1'b0) ##1 rd_s(flag_select_n_o)
		##1 ((done_o && rsp_o.granted && rsp_o.rdata == 8'h00)
		or (##[4:5] (done_o && !rsp_o.granted && rsp_o.rdata == 8'hff)))) else $error("acquire shape");
endmodule
bind dual_port_flag_ctrl flag_ctrl_sva flag_ctrl_sva_i (.clk_i, .reset_i, .cmd_valid_i, .cmd_i,
	.cmd_ready_o, .done_o, .rsp_o, .addr_o, .mem_select_n_o, .flag_select_n_o, .rw_o, .oe_n_o,
	.data_o, .data_oe_o);

//--- verification/flag_ram_model.sv
// behavioural shared ram with eight flags; far port driven by the bench
module flag_ram_model #(
	parameter int DELAY_NS = 0
) (
	input wire logic [11:0] addr_i,
	input wire logic mem_select_n_i,
	input wire logic flag_select_n_i,
	input wire logic rw_i,
	input wire logic oe_n_i,
	input wire logic [7:0] data_i,
	output logic [7:0] data_o,
	input wire logic [2:0] other_idx_i,
	input wire logic other_bit_i,
	input wire logic other_stb_i
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem [4096];
	logic [7:0] held = 8'hff;
	logic [7:0] last = 8'h00;
	int tok [8] = '{default: 1};
	bit pend [2][8] = '{'{default: 1}, '{default: 0}};
	// request latch then token hand-over, one side at a time
	function automatic void side_write(int s, int i, bit b);
		pend[s][i] = !b;
		if (tok[i] == s + 1 && b) tok[i] = pend[1 - s][i] ? 2 - s : 0;
		else if (tok[i] == 0 && !b) tok[i] = s + 1;
	endfunction
	// writes land on the rising edge of rw
	always @(posedge rw_i)
		if (!flag_select_n_i && mem_select_n_i) side_write(0, addr_i[2:0], data_i[0]);
		else if (flag_select_n_i && !mem_select_n_i) mem[addr_i] = data_i;
	always @(posedge other_stb_i) side_write(1, other_idx_i, other_bit_i);
	// flag value frozen while select and enable stay low; wait 1 ns so the address has landed
	always @(negedge (flag_select_n_i | oe_n_i)) begin
		#1;
		held = tok[addr_i[2:0]] == 1 ? 8'h00 : 8'hff;
	end
	wire logic fdrv = rw_i && !oe_n_i && !flag_select_n_i && mem_select_n_i;
	wire logic mdrv = rw_i && !oe_n_i && flag_select_n_i && !mem_select_n_i;
	assign #(DELAY_NS) data_o = fdrv ? held : mdrv ? mem[addr_i] : ~last;
	always @(data_o) if (fdrv || mdrv) last = data_o;
endmodule

//--- verification/tb_top.sv
// self-checking bench of the flag controller against a reference model
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin mismatches++; \
		$display("ERROR %s expected %h seen %h", nm, e, s); end end
	logic clk_i = 0, reset_i = 1, cmd_valid_i = 0, done_o, cmd_ready_o, rw_o, oe_n_o, data_oe_o;
	logic mem_select_n_o, flag_select_n_o, ostb = 0, obit = 1;
	logic [2:0] oidx = 0;
	logic [7:0] data_o, data_i, rmem [int];
	logic [11:0] addr_o, q [8];
	dual_port_flag_pkg::cmd_t cmd_i = '0;
	dual_port_flag_pkg::rsp_t rsp_o;
	int mismatches = 0, n_tests = 0, own [8] = '{default: 1}, seed = 32'h100dea12;
	bit pend [2][8] = '{'{default: 1}, '{default: 0}};
	dual_port_flag_ctrl dual_port_flag_ctrl_i (.clk_i, .reset_i, .cmd_valid_i, .cmd_i, .cmd_ready_o,
		.done_o, .rsp_o, .addr_o, .mem_select_n_o, .flag_select_n_o, .rw_o, .oe_n_o, .data_o,
		.data_oe_o, .data_i);
	flag_ram_model #(.DELAY_NS(40)) flag_ram_model_i (.addr_i(addr_o), .mem_select_n_i(mem_select_n_o),
		.flag_select_n_i(flag_select_n_o), .rw_i(rw_o), .oe_n_i(oe_n_o), .data_i(data_o),
		.data_o(data_i), .other_idx_i(oidx), .other_bit_i(obit), .other_stb_i(ostb));
	initial forever #50 clk_i = ~clk_i;
	// reference token bookkeeping, side 0 is the controller
	function automatic void ref_write(int s, int i, bit b);
		pend[s][i] = !b;
		if (own[i] == s + 1 && b) own[i] = pend[1 - s][i] ? 2 - s : 0;
		else if (own[i] == 0 && !b) own[i] = s + 1;
	endfunction
	task automatic run(dual_port_flag_pkg::cmd_kind_t k, logic [11:0] a, logic [7:0] d);
		int n;
		n = 0;
		cmd_i <= '{k, a, d};
		cmd_valid_i <= 1;
		do @(posedge clk_i); while (cmd_ready_o !== 1'b1 && ++n < 60);
		cmd_valid_i <= 0;
		do @(posedge clk_i); while (done_o !== 1'b1 && ++n < 60);
		if (n >= 60) mismatches++;
	endtask
	task automatic chk_flag(int i);
		run(dual_port_flag_pkg::CMD_FLAG_READ, 12'($random(seed)) & 12'hff8 | 12'(i), 8'h00);
		`CHK("flag", own[i] == 1 ? 8'h00 : 8'hff, rsp_o.rdata)
	endtask
	task automatic acq(int i);
		int won;
		run(dual_port_flag_pkg::CMD_FLAG_ACQUIRE, 12'($random(seed)) & 12'hff8 | 12'(i), 8'h00);
		ref_write(0, i, 0);
		won = own[i] == 1;
		if (!won) ref_write(0, i, 1);
		`CHK("grant", 1'(won), rsp_o.granted)
	endtask
	task automatic oth(int i, bit b);
		oidx <= 3'(i);
		obit <= b;
		ostb <= 1;
		@(posedge clk_i);
		ostb <= 0;
		@(posedge clk_i);
		ref_write(1, i, b);
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		#300000;
		mismatches++;
		results();
	end
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (10) @(posedge clk_i);
		reset_i <= 0;
		for (int i = 0; i < 8; i++) ref_write(0, i, 1);
		for (int i = 0; i < 8; i++) chk_flag(i);
		$display("test init done");
		for (int k = 0; k < 8; k++) begin
			q[k] = 12'($random(seed));
			rmem[q[k]] = 8'($random(seed));
			run(dual_port_flag_pkg::CMD_MEM_WRITE, q[k], rmem[q[k]]);
		end
		foreach (q[k]) begin
			run(dual_port_flag_pkg::CMD_MEM_READ, q[k], 8'h00);
			`CHK("mem", rmem[q[k]], rsp_o.rdata)
		end
		$display("test memory done");
		for (int i = 0; i < 8; i++) begin
			acq(i);
			oth(i, 0);
			chk_flag(i);
			run(dual_port_flag_pkg::CMD_FLAG_RELEASE, 12'(i), 8'hff);
			ref_write(0, i, 1);
			chk_flag(i);
			acq(i);
			oth(i, 1);
			chk_flag(i);
			acq(i);
		end
		$display("test flags done");
		results();
	end
endmodule
